// *** hw/ufe_consts.vh ***
// register map, field positions, reset values and timing counts
`ifndef UFE_CONSTS_VH
`define UFE_CONSTS_VH
// register offsets
`define UFE_OFS_TXBUF   8'hb7
`define UFE_OFS_RXBUF   8'hb8
`define UFE_OFS_DIV     8'hb9
`define UFE_OFS_MAIN    8'hba
`define UFE_OFS_RXSC    8'hbb
`define UFE_OFS_ICS     8'hbc
// main_control_status fields
`define UFE_M_PAR_EN    7
`define UFE_M_PSEL_HI   6
`define UFE_M_PSEL_LO   5
`define UFE_M_LEN_HI    4
`define UFE_M_LEN_LO    3
// receive_status_control fields
`define UFE_R_ATTENTION_MODE      2
// interrupt_clock_source_control fields
`define UFE_I_STOP_COUNT_SELECT      7
`define UFE_I_FORCE     6
`define UFE_I_TXPIN     5
`define UFE_I_SYNC      4
`define UFE_I_RXEXT     3
`define UFE_I_TXEXT     2
`define UFE_I_RXIE      1
`define UFE_I_TXIE      0
// frame length codes
`define UFE_LEN_8       2'b00
`define UFE_LEN_7       2'b01
`define UFE_LEN_9       2'b10
`define UFE_LEN_LOOP    2'b11
// parity select codes
`define UFE_PAR_ODD     2'b00
`define UFE_PAR_EVEN    2'b01
`define UFE_PAR_MARK    2'b10
`define UFE_PAR_SPACE   2'b11
// reset values
`define UFE_RST_CFG     8'h00
`define UFE_RST_DIV     8'h00
`define UFE_RST_TXE     1'b1
// timing in 16x oversample ticks; receive shifter width in bits
`define UFE_PH_LAST     4'hf
`define UFE_PH_CONFIRM  4'h8
`define UFE_PH_SMP_A    4'h7
`define UFE_PH_SMP_B    4'h8
`define UFE_PH_SMP_C    4'h9
`define UFE_RX_SH_W     4'd11
`endif

// *** hw/ufe_rx.v ***
// receive shifter: start detect, oversampling, frame decode
`default_nettype none
`include "ufe_consts.vh"
module ufe_rx (
    input  wire       ref_clk,
    input  wire       arst_n,
    input  wire       tick,
    input  wire       sync_mode,
    input  wire       line,
    input  wire [3:0] data_bits,
    input  wire       par_on,
    input  wire [1:0] par_sel,
    output reg        done,
    output reg  [8:0] data,
    output reg        par_err,
    output reg        frm_err,
    output reg        force_line_low
);
    localparam [1:0] S_IDLE  = 2'd0; // watching for a low line
    localparam [1:0] S_START = 2'd1; // confirming the start bit
    localparam [1:0] S_BITS  = 2'd2; // shifting frame bits
    localparam [1:0] S_WAIT  = 2'd3; // low stop: wait for line high

    reg [1:0]  state;    // receiver state
    reg [3:0]  phase;    // 16x phase within a bit
    reg [3:0]  idx;      // bits taken so far
    reg [10:0] shifter;  // receive_shifter, lsb first
    reg [1:0]  smp;      // first two centre samples

    // majority of three centre samples
    function maj3;
        input a;
        input b;
        input c;
        begin
            maj3 = (a & b) | (a & c) | (b & c);
        end
    endfunction

    // expected parity bit for the selected scheme
    function par_bit;
        input [8:0] d;
        input [1:0] sel;
        begin
            case (sel)
                `UFE_PAR_ODD:  par_bit = ~^d;
                `UFE_PAR_EVEN: par_bit = ^d;
                `UFE_PAR_MARK: par_bit = 1'b1;
                default:       par_bit = 1'b0;
            endcase
        end
    endfunction

    wire [3:0]  nbits = data_bits + {3'b000, par_on} + 4'd1; // one stop
    wire        bit_val = sync_mode ? line : maj3(smp[1], smp[0], line);
    wire        take = tick & (sync_mode | (phase == `UFE_PH_SMP_C));
    wire [10:0] next_sh = {bit_val, shifter[10:1]};
    wire [10:0] frame = next_sh >> (`UFE_RX_SH_W - nbits);
    wire [8:0]  dmask = (data_bits == 4'd7) ? 9'h07f :
                        (data_bits == 4'd8) ? 9'h0ff : 9'h1ff;
    wire [8:0]  dval = frame[8:0] & dmask;

    // bit sequencing and frame completion
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state   <= S_IDLE;
            phase   <= 4'h0;
            idx     <= 4'h0;
            shifter <= 11'h000;
            smp     <= 2'b00;
            done    <= 1'b0;
            data    <= 9'h000;
            par_err <= 1'b0;
            frm_err <= 1'b0;
            force_line_low     <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    idx <= 4'h0;
                    if (tick && !line)
                    begin
                        // sync frames skip the half-bit check
                        state <= sync_mode ? S_BITS : S_START;
                        phase <= 4'h1;
                    end
                end
                S_START:
                begin
                    if (tick)
                    begin
                        phase <= phase + 4'h1;
                        if (phase == `UFE_PH_CONFIRM && line)
                            state <= S_IDLE;
                        else if (phase == `UFE_PH_LAST)
                            state <= S_BITS;
                    end
                end
                S_BITS:
                begin
                    if (tick)
                        phase <= phase + 4'h1;
                    if (tick && (phase == `UFE_PH_SMP_A || phase == `UFE_PH_SMP_B))
                        smp <= {smp[0], line};
                    if (take)
                    begin
                        shifter <= next_sh;
                        idx     <= idx + 4'h1;
                        if (idx == nbits - 4'd1)
                        begin
                            done    <= 1'b1;
                            data    <= dval;
                            par_err <= par_on & (par_bit(dval, par_sel) != frame[data_bits]);
                            frm_err <= ~bit_val;
                            force_line_low     <= (frame == 11'h000);
                            state   <= bit_val ? S_IDLE : S_WAIT;
                        end
                    end
                end
                S_WAIT:
                begin
                    // a held-low line must not start fresh frames
                    if (line)
                        state <= S_IDLE;
                end
                default:
                    state <= S_IDLE;
            endcase
        end
    end
endmodule // ufe_rx
`default_nettype wire

// *** hw/ufe_top.v ***
// serial frame engine: registers, clocking and transmitter
`default_nettype none
`include "ufe_consts.vh"
module ufe_top (
    input  wire       ref_clk,
    input  wire       arst_n,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       serial_in_pin,
    output reg        serial_out_pin,
    output wire       serial_out_oe,
    input  wire       serial_clock_in,
    output reg        serial_clock_out,
    output wire       serial_clock_oe,
    output wire       rx_irq_pending,
    output wire       tx_irq_pending
);
    // software-visible state
    reg [7:0]  main_cfg;      // writable bits of main_control_status
    reg [7:0]  ics_cfg;       // interrupt_clock_source_control
    reg [7:0]  baud_div;      // internal generator divisor
    reg [7:0]  tx_buf;        // transmit_buffer
    reg [7:0]  rx_buf;        // receive_buffer
    reg        tx_empty;      // tx_empty_flag
    reg        rx_full;       // rx_full_flag
    reg        overrun;       // overrun_flag
    reg        frm_err;       // framing_error_flag
    reg        par_err;       // parity_error_flag
    reg        line_brk;      // line_break_flag
    reg        rx_ninth;      // rx_ninth_bit
    reg        attention;     // attention_mode
    reg        receiving;     // receiving_status
    // clocking
    reg [7:0]  base_cnt;      // divisor counter
    reg        ck_prev;       // last sample of the clock pin
    // transmitter
    reg        transmitting;  // transmitting_status
    reg [11:0] tx_shift;      // transmit_shifter, lsb leaves first
    reg [3:0]  tx_left;       // bits still to send
    reg [3:0]  tx_phase;      // 16x phase within a bit
    // receiver results
    wire       rx_done;
    wire [8:0] rx_data;
    wire       rx_perr;
    wire       rx_ferr;
    wire       rx_brk;

    // expected parity bit for the selected scheme
    function par_bit;
        input [8:0] d;
        input [1:0] sel;
        begin
            case (sel)
                `UFE_PAR_ODD:  par_bit = ~^d;
                `UFE_PAR_EVEN: par_bit = ^d;
                `UFE_PAR_MARK: par_bit = 1'b1;
                default:       par_bit = 1'b0;
            endcase
        end
    endfunction

    // field views
    wire [1:0] frame_len = {main_cfg[`UFE_M_LEN_HI], main_cfg[`UFE_M_LEN_LO]};
    wire       nine_bit = main_cfg[`UFE_M_LEN_HI];
    wire       loopback = (frame_len == `UFE_LEN_LOOP);
    wire       tx_ninth_bit = main_cfg[`UFE_M_PSEL_LO];
    wire [1:0] par_sel = {main_cfg[`UFE_M_PSEL_HI], main_cfg[`UFE_M_PSEL_LO]};
    wire       par_on = main_cfg[`UFE_M_PAR_EN] & ~nine_bit;
    wire       sync_mode = ics_cfg[`UFE_I_SYNC];
    wire [3:0] data_bits = nine_bit ? 4'd9 :
                           (frame_len == `UFE_LEN_7) ? 4'd7 : 4'd8;
    wire [3:0] stop_bits = ics_cfg[`UFE_I_STOP_COUNT_SELECT] ? 4'd2 : 4'd1;
    wire [3:0] tx_bits = 4'd1 + data_bits + {3'b000, par_on} + stop_bits;

    // bus decode
    wire wr_main  = reg_wr && reg_addr == `UFE_OFS_MAIN;
    wire wr_rxsc  = reg_wr && reg_addr == `UFE_OFS_RXSC;
    wire wr_ics   = reg_wr && reg_addr == `UFE_OFS_ICS;
    wire wr_div   = reg_wr && reg_addr == `UFE_OFS_DIV;
    wire wr_transmit_buffer  = reg_wr && reg_addr == `UFE_OFS_TXBUF;
    wire rd_rxsc  = reg_rd && reg_addr == `UFE_OFS_RXSC;
    wire rd_receive_buffer  = reg_rd && reg_addr == `UFE_OFS_RXBUF;
    wire any_err  = overrun | frm_err | par_err | line_brk;

    // clock sources: internal generator or external pin
    wire base_tick = (base_cnt == baud_div);
    wire int_rise  = base_tick & ~serial_clock_out;
    wire int_fall  = base_tick & serial_clock_out;
    wire ext_rise  = serial_clock_in & ~ck_prev;
    wire ext_fall  = ~serial_clock_in & ck_prev;
    // sync mode: one event per bit; async: 16x ticks
    wire tx_src = ics_cfg[`UFE_I_TXEXT] ? ext_rise :
                  (sync_mode ? int_rise : base_tick);
    wire rx_src = ics_cfg[`UFE_I_RXEXT] ? (sync_mode ? ext_fall : ext_rise) :
                  (sync_mode ? int_fall : base_tick);

    // transmitter timing
    wire tx_bit_end = tx_src & (sync_mode | (tx_phase == `UFE_PH_LAST));
    wire tx_last = tx_bit_end & (tx_left == 4'd1);
    // a write in the same cycle defers the move, so no byte is lost
    wire tx_load = ~tx_empty & ~wr_transmit_buffer & tx_src &
                   (~transmitting | tx_last);
    wire tx_line = transmitting ? tx_shift[0] : 1'b1;

    // next frame image: start at bit 0, ones fill every stop slot
    reg [11:0] next_frame;
    always @*
    begin
        next_frame = 12'hfff;
        case (frame_len)
            `UFE_LEN_7:
                next_frame = {3'b111, par_on ? par_bit({2'b00, tx_buf[6:0]}, par_sel) : 1'b1,
                              tx_buf[6:0], 1'b0};
            `UFE_LEN_8:
                next_frame = {2'b11, par_on ? par_bit({1'b0, tx_buf}, par_sel) : 1'b1,
                              tx_buf, 1'b0};
            default:
                next_frame = {2'b11, tx_ninth_bit, tx_buf, 1'b0};
        endcase
    end

    // interrupt request levels
    assign rx_irq_pending = rx_full & ics_cfg[`UFE_I_RXIE];
    assign tx_irq_pending = tx_empty & ics_cfg[`UFE_I_TXIE];
    // pin enables
    assign serial_out_oe = ics_cfg[`UFE_I_TXPIN];
    // drive the shared clock only when no source is external
    assign serial_clock_oe = sync_mode & ~ics_cfg[`UFE_I_TXEXT] &
                             ~ics_cfg[`UFE_I_RXEXT];

    // receiver; loopback takes our own output
    ufe_rx u_rx (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .tick      (rx_src),
        .sync_mode (sync_mode),
        .line      (loopback ? serial_out_pin : serial_in_pin),
        .data_bits (data_bits),
        .par_on    (par_on),
        .par_sel   (par_sel),
        .done      (rx_done),
        .data      (rx_data),
        .par_err   (rx_perr),
        .frm_err   (rx_ferr),
        .force_line_low       (rx_brk)
    );

    // configuration registers
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            main_cfg <= `UFE_RST_CFG;
            ics_cfg  <= `UFE_RST_CFG;
            baud_div <= `UFE_RST_DIV;
            tx_buf   <= 8'h00;
        end
        else
        begin
            if (wr_main)
                main_cfg <= {reg_wdata[7:3], 3'b000}; // low bits are status
            if (wr_ics)
                ics_cfg <= reg_wdata;
            if (wr_div)
                baud_div <= reg_wdata;
            if (wr_transmit_buffer)
                tx_buf <= reg_wdata;
        end
    end

    // baud generator and clock pin sampling
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            base_cnt         <= 8'h00;
            serial_clock_out <= 1'b0;
            ck_prev          <= 1'b0;
        end
        else
        begin
            ck_prev  <= serial_clock_in;
            // a new divisor or reaching the divisor restarts the count from zero
            base_cnt <= (base_tick || wr_div) ? 8'h00 : base_cnt + 8'h01;
            // sync bit clock runs at half the tick rate
            if (base_tick)
                serial_clock_out <= ~serial_clock_out;
        end
    end

    // transmit shifter and status
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            transmitting <= 1'b0;
            tx_shift     <= 12'hfff;
            tx_left      <= 4'h0;
            tx_phase     <= 4'h0;
            tx_empty     <= `UFE_RST_TXE;
        end
        else
        begin
            if (tx_load)
            begin
                tx_shift     <= next_frame;
                tx_left      <= tx_bits;
                tx_phase     <= 4'h0;
                transmitting <= 1'b1;
            end
            else if (transmitting && tx_src)
            begin
                tx_phase <= tx_phase + 4'h1;
                if (tx_bit_end)
                begin
                    // data changes on rising events in sync mode
                    tx_shift <= {1'b1, tx_shift[11:1]};
                    tx_left  <= tx_left - 4'd1;
                    if (tx_last)
                        transmitting <= 1'b0;
                end
            end
            // load and write never coincide
            if (tx_load)
                tx_empty <= 1'b1;
            else if (wr_transmit_buffer)
                tx_empty <= 1'b0;
        end
    end

    // output pin register; break control wins over data
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            serial_out_pin <= 1'b1;
        else
            serial_out_pin <= ics_cfg[`UFE_I_FORCE] ? 1'b0 : tx_line;
    end

    // receive buffer and error flags; hardware set beats clear
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_buf    <= 8'h00;
            rx_full   <= 1'b0;
            overrun   <= 1'b0;
            frm_err   <= 1'b0;
            par_err   <= 1'b0;
            line_brk  <= 1'b0;
            rx_ninth  <= 1'b0;
            attention <= 1'b0;
            receiving <= 1'b0;
        end
        else
        begin
            if (rx_done)
                rx_buf <= rx_data[7:0];
            // full flag
            if (rx_done)
                rx_full <= 1'b1;
            else if (rd_receive_buffer)
                rx_full <= 1'b0;
            // overrun: new frame while old one unread
            if (rx_done && rx_full && !rd_receive_buffer)
                overrun <= 1'b1;
            else if (rd_rxsc)
                overrun <= 1'b0;
            if (rx_done && rx_ferr)
                frm_err <= 1'b1;
            else if (rd_rxsc)
                frm_err <= 1'b0;
            if (rx_done && rx_perr)
                par_err <= 1'b1;
            else if (rd_rxsc)
                par_err <= 1'b0;
            if (rx_done && rx_brk)
                line_brk <= 1'b1;
            else if (rd_rxsc)
                line_brk <= 1'b0;
            // ninth bit only tracks nine-bit frames
            if (rx_done && nine_bit)
                rx_ninth <= rx_data[8];
            // software write takes priority over the auto clear
            if (wr_rxsc)
                attention <= reg_wdata[`UFE_R_ATTENTION_MODE];
            else if (rx_done && nine_bit && rx_data[8])
                attention <= 1'b0;
            // receiving tracks error or break until the line returns high
            if (rx_done && (rx_ferr || rx_brk))
                receiving <= 1'b1;
            else if (loopback ? serial_out_pin : serial_in_pin)
                receiving <= 1'b0;
        end
    end

    // read data, valid the cycle after the strobe
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `UFE_OFS_MAIN:
                    reg_rdata <= {main_cfg[7:3], any_err, rx_full, tx_empty};
                `UFE_OFS_RXSC:
                    reg_rdata <= {overrun, frm_err, par_err, line_brk,
                                  rx_ninth, attention, transmitting, receiving};
                `UFE_OFS_ICS:
                    reg_rdata <= ics_cfg;
                `UFE_OFS_DIV:
                    reg_rdata <= baud_div;
                `UFE_OFS_TXBUF:
                    reg_rdata <= tx_buf;
                `UFE_OFS_RXBUF:
                    reg_rdata <= rx_buf;
                default:
                    reg_rdata <= 8'h00; // unmapped reads as zero
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end
endmodule // ufe_top
`default_nettype wire

// *** bench/ufe_top_props.sv ***
// port checker for the serial frame engine
`default_nettype none
`include "ufe_consts.vh"
module ufe_chk (
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       serial_in_pin,
    input wire logic       serial_out_pin,
    input wire logic       serial_out_oe,
    input wire logic       serial_clock_in,
    input wire logic       serial_clock_out,
    input wire logic       serial_clock_oe,
    input wire logic       rx_irq_pending,
    input wire logic       tx_irq_pending
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // write strobes decoded per register
    wire ics_wr = reg_wr && reg_addr == `UFE_OFS_ICS;
    wire txb_wr = reg_wr && reg_addr == `UFE_OFS_TXBUF;
    // pin enable bit lands on the enable one edge later
    property p_oe; ics_wr |=> serial_out_oe == $past(reg_wdata[`UFE_I_TXPIN]); endproperty
    a_oe: assert property (p_oe)
        else $error("tx pin enable mismatch");
    // clock pin driven only in sync mode with both sources internal
    property p_ck_oe;
        ics_wr |=> serial_clock_oe == ($past(reg_wdata[4]) && !$past(reg_wdata[3])
            && !$past(reg_wdata[2]));
    endproperty
    a_ck_oe: assert property (p_ck_oe)
        else $error("clock enable mismatch");
    property p_tx_off; ics_wr && !reg_wdata[`UFE_I_TXIE] |=> !tx_irq_pending; endproperty
    a_tx_off: assert property (p_tx_off)
        else $error("tx request not gated");
    property p_rx_off; ics_wr && !reg_wdata[`UFE_I_RXIE] |=> !rx_irq_pending; endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("rx request not gated");
    property p_receive_buffer; reg_rd && reg_addr == `UFE_OFS_RXBUF |=> !rx_irq_pending; endproperty
    a_receive_buffer: assert property (p_receive_buffer)
        else $error("rx full not cleared by read");
    property p_transmit_buffer; txb_wr |=> !tx_irq_pending; endproperty
    a_transmit_buffer: assert property (p_transmit_buffer)
        else $error("tx empty not cleared by write");
    // read data only in the cycle after a read strobe
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its cycle");
    // forced low one edge after the control lands
    property p_force; ics_wr && reg_wdata[`UFE_I_FORCE] ##1 !ics_wr |=> !serial_out_pin;
    endproperty
    a_force: assert property (p_force)
        else $error("line not forced low");
    c_rx: cover property ($rose(rx_irq_pending));
    c_tx: cover property (serial_out_oe && $fell(serial_out_pin));
    c_st: cover property (reg_rd && reg_addr == `UFE_OFS_RXSC);
endmodule // ufe_chk
bind ufe_top ufe_chk chk_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .serial_clock_in(serial_clock_in),
    .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
    .rx_irq_pending(rx_irq_pending), .tx_irq_pending(tx_irq_pending));
`default_nettype wire

// *** bench/ufe_peer.sv ***
// remote async transceiver at 16 cycles a bit (divisor 0)
`default_nettype none
module ufe_peer (
    input  wire logic ref_clk,
    input  wire logic tx_line,
    output var  logic rx_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q [$]; // bytes caught from the device
    logic [7:0] shf;       // catch shifter
    initial rx_line = 1'b1;
    // bits lsb first, start included; call right after an edge
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++)
        begin
            rx_line <= bits[i];
            repeat (16) @(posedge ref_clk);
        end
        rx_line <= 1'b1;
    endtask
    // 8N1 catch, sampled at bit centres
    always
    begin
        @(negedge tx_line);
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (16) @(posedge ref_clk);
            shf[i] = tx_line;
        end
        repeat (16) @(posedge ref_clk);
        got_q.push_back(shf);
    end
endmodule // ufe_peer
`default_nettype wire

// *** bench/usart_frame_engine_tb.sv ***
// self-checking bench for the serial frame engine
`default_nettype none
`include "ufe_consts.vh"
module usart_frame_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} ufe_row_t;
    logic       ref_clk   = 1'b0;
    logic       arst_n    = 1'b0;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic       ck_in     = 1'b0; // tied: external clock not exercised
    wire  [7:0] reg_rdata;
    wire        pin, oe, ck_out, ck_oe, rx_irq, tx_irq, rx_line;
    wire        tx_line   = oe ? pin : 1'b1; // pulled up when not driven
    int         fail_count = 0;
    int         compares   = 0;
    int         cyc        = 0;
    logic [7:0] rv;
    // write, then read back expected value
    ufe_row_t   rows [9] = '{'{8'hb9, 8'ha5, 8'ha5}, '{8'hb9, 8'h00, 8'h00},
        '{8'hbc, 8'h03, 8'h03}, '{8'hbc, 8'h20, 8'h20}, '{8'hba, 8'hf8, 8'hf9},
        '{8'hba, 8'h00, 8'h01}, '{8'hbb, 8'h04, 8'h04}, '{8'hbb, 8'h00, 8'h00},
        '{8'h10, 8'hff, 8'h00}};
    always #5 ref_clk = ~ref_clk;
    ufe_top dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_in_pin(rx_line), .serial_out_pin(pin), .serial_out_oe(oe),
        .serial_clock_in(ck_in), .serial_clock_out(ck_out), .serial_clock_oe(ck_oe),
        .rx_irq_pending(rx_irq), .tx_irq_pending(tx_irq));
    ufe_peer peer_u (.ref_clk(ref_clk), .tx_line(tx_line), .rx_line(rx_line));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        @(posedge ref_clk);
    endtask
    // data taken just after the edge that ends the answer cycle's start
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
        @(posedge ref_clk);
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        rd(a, rv);
        chk(n, e, rv);
    endtask
    task automatic wait_rx;
        for (int k = 0; k < 3000 && rx_irq !== 1'b1; k++) @(posedge ref_clk);
    endtask
    task give_verdict;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rchk("main", `UFE_OFS_MAIN, 8'h01);
        rchk("rxsc", `UFE_OFS_RXSC, 8'h00);
        rchk("ics", `UFE_OFS_ICS, 8'h00);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rchk("row", rows[i].a, rows[i].e);
        end
        // two bytes back to back out to the peer
        wr(`UFE_OFS_ICS, 8'h21);
        @(negedge ref_clk) chk("tx_irq", 8'h01, {7'h00, tx_irq});
        @(posedge ref_clk);
        wr(`UFE_OFS_TXBUF, 8'h5a);
        wr(`UFE_OFS_TXBUF, 8'hc3);
        rchk("main", `UFE_OFS_MAIN, 8'h00);
        rchk("transmitting_status", `UFE_OFS_RXSC, 8'h02);
        repeat (400) @(posedge ref_clk);
        rchk("transmitting_status", `UFE_OFS_RXSC, 8'h00);
        chk("byte0", 8'h5a, peer_u.got_q[0]);
        chk("byte1", 8'hc3, peer_u.got_q[1]);
        // receive, then overrun with two unread frames
        wr(`UFE_OFS_ICS, 8'h22);
        peer_u.send(12'h278, 10);
        wait_rx();
        @(negedge ref_clk) chk("rx_irq", 8'h01, {7'h00, rx_irq});
        @(posedge ref_clk);
        rchk("receive_buffer", `UFE_OFS_RXBUF, 8'h3c);
        rchk("main", `UFE_OFS_MAIN, 8'h01);
        peer_u.send(12'h222, 10);
        peer_u.send(12'h244, 10);
        rchk("err", `UFE_OFS_MAIN, 8'h07);
        rchk("ovr", `UFE_OFS_RXSC, 8'h80);
        rchk("clr", `UFE_OFS_RXSC, 8'h00);
        rd(`UFE_OFS_RXBUF, rv);
        // low stop bit, then an all-low frame
        peer_u.send(12'h0aa, 10);
        rd(`UFE_OFS_RXSC, rv);
        chk("fe", 8'h41, rv);
        rd(`UFE_OFS_RXBUF, rv);
        peer_u.send(12'h000, 10);
        rd(`UFE_OFS_RXSC, rv);
        chk("brk", 8'h51, rv);
        rd(`UFE_OFS_RXBUF, rv);
        // every parity select with a wrong parity bit
        for (int p = 0; p < 4; p++)
        begin
            wr(`UFE_OFS_MAIN, 8'h80 | 8'(p << 5));
            peer_u.send({2'b01, ((p == 1 || p == 2) ? 1'b0 : 1'b1), 8'h01, 1'b0}, 11);
            rchk("par", `UFE_OFS_RXSC, 8'h20);
            rchk("pdat", `UFE_OFS_RXBUF, 8'h01);
        end
        // loopback nine bits, ninth set, attention armed
        wr(`UFE_OFS_MAIN, 8'h38);
        wr(`UFE_OFS_RXSC, 8'h04);
        wr(`UFE_OFS_TXBUF, 8'h81);
        wait_rx();
        repeat (30) @(posedge ref_clk);
        rchk("loop", `UFE_OFS_RXBUF, 8'h81);
        rchk("ninth", `UFE_OFS_RXSC, 8'h08);
        wr(`UFE_OFS_ICS, 8'h60);
        @(negedge ref_clk) chk("force", 8'h00, {7'h00, pin});
        @(posedge ref_clk);
        wr(`UFE_OFS_ICS, 8'h20);
        @(negedge ref_clk) chk("idle", 8'h01, {7'h00, pin});
        give_verdict();
    end
endmodule // usart_frame_engine_tb
`default_nettype wire
